// *** rtl/amps_pkg.sv ***
// constants shared by the memory port slave and the master-side end
// assumes one clock domain and a single transfer in flight at a time
package amps_pkg;
    // ------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 29;
    localparam int DATA_W = 64;
    localparam int BANK_N = 8;
    localparam int PORT_MAX = 9;
    localparam int WIDE_LO = 3;
    localparam int WIDE_HI = 6;
    // ------------------------------------------------------------
    // transfer encodings
    // ------------------------------------------------------------
    localparam logic [1:0] TRANS_IDLE = 2'h0;
    localparam logic [1:0] TRANS_BUSY = 2'h1;
    localparam logic [1:0] TRANS_NSEQ = 2'h2;
    localparam logic [1:0] TRANS_SEQ = 2'h3;
    localparam logic [2:0] SIZE_DWORD = 3'h3;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic [2:0] BURST_INCR = 3'h1;
    localparam logic [2:0] BURST_INCR4 = 3'h3;
    localparam logic [2:0] RESP_OKAY = 3'h0;
    localparam logic [2:0] RESP_ERROR = 3'h1;
    localparam int RESP_EXCL_BIT = 2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int ACCESS_NS = 100;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYC);
endpackage : amps_pkg

// *** rtl/amps_if.sv ***
// interface joining the master layer and the memory port slave
// assumes both ends run on i_ref_clk
interface amps_if;
    import amps_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
    logic [2:0] burst;
    logic excl;
    logic unaligned_transfer_flag;
    logic [BANK_N-1:0] bank_select;
    logic memory_global_select;
    logic ready_in;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic ready_out;
    logic [2:0] resp;
    modport slave (
        input addr, trans, write, size, burst, excl,
        input unaligned_transfer_flag, bank_select, memory_global_select,
        input ready_in, wdata,
        output rdata, ready_out, resp
    );
    modport master (
        output addr, trans, write, size, burst, excl,
        output unaligned_transfer_flag, bank_select, memory_global_select,
        output ready_in, wdata,
        input rdata, ready_out, resp
    );
endinterface : amps_if

// *** rtl/amps_slave.sv ***
// memory port slave: decode, check, wait states, response
// assumes master end drives the interface synchronously to i_ref_clk
module amps_slave #(
    parameter int PORT_NUM = 0,
    parameter bit WIDE = 1'b0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    amps_if.slave bus,
    input wire logic i_controller_enable_bit,
    input wire logic i_low_power_bit,
    input wire logic [amps_pkg::BANK_N-1:0] i_bank_write_protect,
    output logic o_mem_req,
    output logic o_mem_write,
    output logic [amps_pkg::ADDR_W-1:0] o_mem_addr,
    output logic [2:0] o_mem_size,
    output logic [amps_pkg::DATA_W-1:0] o_mem_wdata,
    output logic [3:0] o_burst_beats,
    input wire logic [amps_pkg::DATA_W-1:0] i_mem_rdata
);
    import amps_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_ACCESS, S_ERR1, S_ERR2} amps_state_type;
    amps_state_type state;
    logic [3:0] wait_cnt;
    logic [2:0] burst_q;
    logic excl_q;
    logic take;
    logic size_bad;
    logic prot_bad;
    logic off_bad;
    logic [2:0] eff_burst;

    // a new nonseq or seq transfer is taken while bus is ready
    assign take = bus.memory_global_select && bus.trans[1] &&
                  bus.ready_in && state == S_IDLE;
    assign size_bad = (bus.size > SIZE_DWORD) ||
                      (!WIDE && bus.size > SIZE_WORD) ||
                      (WIDE && (PORT_NUM < WIDE_LO || PORT_NUM > WIDE_HI) &&
                       bus.size > SIZE_WORD);
    assign prot_bad = bus.write &&
                      |(bus.bank_select & i_bank_write_protect);
    assign off_bad = !i_controller_enable_bit || i_low_power_bit;
    // undefined incrementing burst treated as four beats
    assign eff_burst = (bus.burst == BURST_INCR) ? BURST_INCR4 :
                       bus.burst;

    // state sequencing
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
        if (!i_rst_b)
            state <= S_IDLE;
        else
            case (state)
                S_IDLE:
                    if (take)
                        state <= (size_bad || prot_bad || off_bad) ?
                                 S_ERR1 : S_ACCESS;
                S_ACCESS:
                    if (wait_cnt == 4'h1)
                        state <= S_IDLE;
                S_ERR1: state <= S_ERR2;
                S_ERR2: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase

    // wait state counter for the memory access
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
        if (!i_rst_b)
            wait_cnt <= 4'h0;
        else if (take)
            wait_cnt <= ACCESS_CNT;
        else if (wait_cnt != 4'h0)
            wait_cnt <= wait_cnt - 4'h1;

    // capture address phase
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
        if (!i_rst_b)
        begin
            o_mem_addr <= '0;
            o_mem_size <= 3'h0;
            o_mem_write <= 1'b0;
            burst_q <= 3'h0;
            excl_q <= 1'b0;
        end
        else if (take)
        begin
            o_mem_addr <= bus.addr;
            o_mem_size <= bus.size;
            o_mem_write <= bus.write;
            burst_q <= eff_burst;
            excl_q <= bus.excl && bus.write;
        end

    // burst length in beats
    always_comb
        case (burst_q)
            3'h2, 3'h3: o_burst_beats = 4'h4;
            3'h4, 3'h5: o_burst_beats = 4'h8;
            3'h6, 3'h7: o_burst_beats = 4'hf; // fifteen beats, the largest value of the 4-bit field
            default: o_burst_beats = 4'h1;
        endcase

    assign o_mem_req = (state == S_ACCESS);

    // write data sampled in the data phase, low half on narrow port
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
        if (!i_rst_b)
            o_mem_wdata <= '0;
        else if (state == S_ACCESS && o_mem_write)
            o_mem_wdata <= WIDE ? bus.wdata :
                           {32'h0, bus.wdata[31:0]};

    // read data, narrow port drives only low half
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
        if (!i_rst_b)
            bus.rdata <= '0;
        else if (state == S_ACCESS && wait_cnt == 4'h1 && !o_mem_write)
            bus.rdata <= WIDE ? i_mem_rdata :
                         {32'h0, i_mem_rdata[31:0]};

    // ready low while the access or first error cycle is pending
    assign bus.ready_out = !(state == S_ACCESS ||
                             state == S_ERR1);

    // response: error for two cycles, exclusive ack, bit one zero
    always_comb
    begin
        bus.resp = RESP_OKAY;
        if (state == S_ERR1 || state == S_ERR2)
            bus.resp = RESP_ERROR;
        else if (state == S_ACCESS && excl_q)
            bus.resp[RESP_EXCL_BIT] = 1'b1;
    end
endmodule : amps_slave

// *** rtl/amps_master.sv ***
// master layer and decoder end: issues one transfer per user request
// assumes slave end on the same clock; unused port holds inputs low
module amps_master (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    amps_if.master bus,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic i_excl,
    input wire logic i_unaligned,
    input wire logic [amps_pkg::ADDR_W-1:0] i_addr,
    input wire logic [2:0] i_size,
    input wire logic [2:0] i_burst,
    input wire logic [amps_pkg::DATA_W-1:0] i_wdata,
    output logic o_busy,
    output logic o_done,
    output logic o_error,
    output logic o_excl_ok,
    output logic [amps_pkg::DATA_W-1:0] o_rdata
);
    import amps_pkg::*;

    typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA} amps_mstate_type;
    amps_mstate_type state;
    logic [ADDR_W-1:0] addr_q;
    logic [2:0] size_q;
    logic [2:0] burst_q;
    logic write_q;
    logic excl_q;
    logic unal_q;
    logic [DATA_W-1:0] wdata_q;

    // sequencing of address and data phases
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
        if (!i_rst_b)
            state <= M_IDLE;
        else
            case (state)
                M_IDLE: if (i_req) state <= M_ADDR;
                M_ADDR: if (bus.ready_out) state <= M_DATA;
                M_DATA: if (bus.ready_out) state <= M_IDLE;
                default: state <= M_IDLE;
            endcase

    // request capture
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
        if (!i_rst_b)
        begin
            addr_q <= '0;
            size_q <= 3'h0;
            burst_q <= 3'h0;
            write_q <= 1'b0;
            excl_q <= 1'b0;
            unal_q <= 1'b0;
            wdata_q <= '0;
        end
        else if (state == M_IDLE && i_req)
        begin
            addr_q <= i_addr;
            size_q <= i_size;
            burst_q <= i_burst;
            write_q <= i_write;
            excl_q <= i_excl;
            unal_q <= i_unaligned && !i_write;
            wdata_q <= i_wdata;
        end

    // address phase drive; idle tied low between transfers
    assign bus.trans = (state == M_ADDR) ? TRANS_NSEQ : TRANS_IDLE;
    assign bus.addr = addr_q;
    assign bus.size = size_q;
    assign bus.burst = burst_q;
    assign bus.write = write_q;
    assign bus.excl = excl_q;
    assign bus.unaligned_transfer_flag = (state != M_IDLE) && unal_q;
    assign bus.memory_global_select = (state == M_ADDR);
    // bank from top three address bits
    assign bus.bank_select = (state == M_ADDR) ?
        BANK_N'(1) << addr_q[ADDR_W-1 -: 3] : '0;
    assign bus.ready_in = bus.ready_out;
    assign bus.wdata = (state == M_DATA) ? wdata_q : '0;
    assign o_busy = (state != M_IDLE);

    // completion capture
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
        if (!i_rst_b)
        begin
            o_done <= 1'b0;
            o_error <= 1'b0;
            o_excl_ok <= 1'b0;
            o_rdata <= '0;
        end
        else
        begin
            o_done <= (state == M_DATA) && bus.ready_out;
            if (state == M_DATA && bus.ready_out)
            begin
                o_error <= bus.resp[0];
                o_rdata <= bus.rdata;
            end
            if (state == M_DATA && bus.resp[RESP_EXCL_BIT])
                o_excl_ok <= 1'b1;
            else if (state == M_IDLE && i_req)
                o_excl_ok <= 1'b0;
        end
endmodule : amps_master

// *** dv/amps_checker.sv ***
// assertions on the signals between master end and memory port slave
// assumes one clock; placed in tb beside the interface instance
module amps_checker
    import amps_pkg::*;
#(
    parameter bit WIDE = 1'b0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [1:0] trans,
    input wire logic write,
    input wire logic [2:0] size,
    input wire logic unaligned_transfer_flag,
    input wire logic [BANK_N-1:0] bank_select,
    input wire logic memory_global_select,
    input wire logic ready_in,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic ready_out,
    input wire logic [2:0] resp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic take;
    // transfer accepted by the slave at this edge
    assign take = memory_global_select && trans[1] && ready_in && ready_out;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    resp_bit1_zero_a: assert property (!resp[1])
        else $error("response bit one set");
    narrow_rdata_a: assert property (!WIDE && ready_out |->
        rdata[63:32] == 32'h0) else $error("upper read half not zero");
    oversize_err_a: assert property (take && (size > 3'h3 ||
        (!WIDE && size == 3'h3)) |=> !ready_out && resp[0] ##1
        ready_out && resp[0]) else $error("oversize not refused");
    ok_wait_a: assert property ($fell(ready_out) && !resp[0] |->
        ##1 !ready_out ##1 ready_out) else $error("wrong wait length");
    err_hold_a: assert property ($rose(resp[0]) |-> !ready_out ##1
        (ready_out && resp[0])) else $error("error not two cycles");
    excl_ack_a: assert property (resp[2] |->
        !ready_out && !resp[0]) else $error("exclusive ack misplaced");
    idle_ready_a: assert property (ready_out && !take |=>
        ready_out) else $error("wait without transfer");
    take_wait_a: assert property (take |=> !ready_out)
        else $error("no wait state after transfer");
    bank_onehot_a: assert property (memory_global_select && trans[1]
        |-> $onehot(bank_select)) else $error("bank select not one-hot");
    unalign_wr_a: assert property (unaligned_transfer_flag &&
        trans[1] |-> !write) else $error("unaligned flag on write");
endmodule : amps_checker

// *** dv/tb.sv ***
// testbench: master end and narrow memory port slave back to back
// assumes a fixed memory read pattern driven by the bench
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import amps_pkg::*;
    logic ref_clk, rst_b, req, wr, excl, unal, en, lp, busy, done, err, exok;
    logic mreq, mwr;
    logic [2:0] size, burst, msize;
    logic [3:0] beats, seen_beats;
    logic [7:0] prot;
    logic [ADDR_W-1:0] addr, maddr;
    logic [DATA_W-1:0] wdata, rdata, mrdata, mwdata, seen_wd;
    logic seen_wr;
    int mismatches, n_checks;
    amps_if amps_if_inst();
    amps_master amps_master_inst (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
        .bus(amps_if_inst.master), .i_req(req), .i_write(wr), .i_excl(excl),
        .i_unaligned(unal), .i_addr(addr), .i_size(size), .i_burst(burst),
        .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_error(err),
        .o_excl_ok(exok), .o_rdata(rdata));
    amps_slave #(.PORT_NUM(0), .WIDE(1'b0)) amps_slave_inst (
        .i_ref_clk(ref_clk), .i_rst_b(rst_b), .bus(amps_if_inst.slave),
        .i_controller_enable_bit(en), .i_low_power_bit(lp),
        .i_bank_write_protect(prot), .o_mem_req(mreq), .o_mem_write(mwr),
        .o_mem_addr(maddr), .o_mem_size(msize), .o_mem_wdata(mwdata),
        .o_burst_beats(beats), .i_mem_rdata(mrdata));
    amps_checker #(.WIDE(1'b0)) amps_checker_inst (.i_ref_clk(ref_clk),
        .i_rst_b(rst_b), .trans(amps_if_inst.trans),
        .write(amps_if_inst.write), .size(amps_if_inst.size),
        .unaligned_transfer_flag(amps_if_inst.unaligned_transfer_flag),
        .bank_select(amps_if_inst.bank_select),
        .memory_global_select(amps_if_inst.memory_global_select),
        .ready_in(amps_if_inst.ready_in), .rdata(amps_if_inst.rdata),
        .ready_out(amps_if_inst.ready_out), .resp(amps_if_inst.resp));
    // clock, 50 ns period
    always #25 ref_clk = ~ref_clk;
    // capture what the slave hands to memory during an access
    always @(posedge ref_clk)
        if (mreq === 1'b1)
        begin
            seen_beats <= beats;
            seen_wr <= mwr;
            seen_wd <= mwdata;
        end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    // one transfer through the master end, waits for its done pulse
    task automatic xfer(input logic w, input logic x, input logic [2:0] sz,
        input logic [2:0] bu, input logic [28:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        {req, wr, excl, size, burst, addr} <= {1'b1, w, x, sz, bu, a};
        @(posedge ref_clk);
        req <= 1'b0;
        do @(negedge ref_clk); while (done !== 1'b1 && ++n < 40);
        check(done, 1'b1);
    endtask : xfer
    // watchdog
    initial
    begin
        #(4000 * 50);
        mismatches++;
        final_report();
    end
    initial
    begin
        {ref_clk, rst_b, req, wr, excl, unal, size, burst, addr} = '0;
        en = 1'b1;
        lp = 1'b0;
        prot = 8'h00;
        wdata = '0;
        mrdata = '0;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        // every burst code on word reads, upper read half stays zero
        for (int b = 0; b < 8; b++)
        begin
            mrdata <= {8{8'(b) + 8'ha1}};
            unal <= b[0];
            xfer(1'b0, 1'b0, SIZE_WORD, 3'(b), 29'h10);
            check(rdata, {32'h0, {4{8'(b) + 8'ha1}}});
            check(seen_beats, b == 0 ? 4'h1 : b < 4 ? 4'h4 :
                b < 6 ? 4'h8 : 4'hf);
            check(seen_wr, 1'b0);
            check(busy, 1'b0);
            check(maddr, 29'h10);
            check(msize, SIZE_WORD);
        end
        $display("test burst reads ended");
        // exclusive write with unaligned flag asked for
        wdata <= 64'hfeedc0de_12345678;
        xfer(1'b1, 1'b1, SIZE_WORD, BURST_INCR4, 29'h100);
        unal <= 1'b0;
        check(err, 1'b0);
        check(exok, 1'b1);
        check(seen_wr, 1'b1);
        check(seen_wd[31:0], 32'h12345678);
        $display("test exclusive write ended");
        // every size code; narrow port refuses above word
        for (int s = 0; s < 8; s++)
        begin
            xfer(1'b1, 1'b0, 3'(s), 3'h0, 29'h40);
            check(err, s > 2);
        end
        $display("test sizes ended");
        // bank 2 write protected: writes refused, reads served
        prot <= 8'h04;
        xfer(1'b1, 1'b0, SIZE_WORD, 3'h0, 29'h0800_0000);
        check(err, 1'b1);
        xfer(1'b0, 1'b0, SIZE_WORD, 3'h0, 29'h0800_0000);
        check(err, 1'b0);
        prot <= 8'h00;
        $display("test protection ended");
        // disabled, then low power, then normal again
        en <= 1'b0;
        xfer(1'b0, 1'b0, SIZE_WORD, 3'h0, 29'h20);
        check(err, 1'b1);
        {en, lp} <= 2'h3;
        xfer(1'b0, 1'b0, SIZE_WORD, 3'h0, 29'h20);
        check(err, 1'b1);
        lp <= 1'b0;
        xfer(1'b0, 1'b0, SIZE_WORD, 3'h0, 29'h20);
        check(err, 1'b0);
        $display("test enable and low power ended");
        final_report();
    end
endmodule : tb
